// file: hdl/cms_alu.sv
/*
 * Four-bit adder and subtracter with a decimal correction stage.
 * Assumes operands are stable from the temporary registers of the core.
 */
`timescale 1ns/100ps
module cms_alu
   import cms_pkg::*;
(
   cms_alu_if.unit alu
);

   logic [4:0] addRaw;
   logic [4:0] subRaw;
   logic       addFix;
   logic [4:0] addOut;
   logic [4:0] subOut;

   // Raw binary sum and difference, one bit wider for carry or borrow.
   assign addRaw = {1'b0, alu.opA} + {1'b0, alu.opB} + {4'h0, alu.carryIn};
   assign subRaw = {1'b0, alu.opA} - {1'b0, alu.opB} - {4'h0, alu.carryIn};

   // Decimal correction is applied only when the decimal flag is set.
   assign addFix = alu.decimal && (addRaw > BCD_LIMIT);
   assign addOut = addFix ? 5'(addRaw + BCD_ADJ) : addRaw;
   assign subOut = (alu.decimal && subRaw[4]) ? 5'(subRaw - BCD_ADJ)
                                              : subRaw;

   // Carry is a carry on addition and a borrow on subtraction.
   assign alu.sum      = alu.subtract ? subOut[3:0] : addOut[3:0];
   assign alu.carryOut = alu.subtract ? subRaw[4] : (addRaw[4] || addFix);

endmodule

// file: hdl/cms_alu_if.sv
/*
 * Operand and result bundle between the core and its arithmetic unit.
 * Assumes the core drives operands and the unit answers combinationally.
 */
`timescale 1ns/100ps
interface cms_alu_if;
   logic [3:0] opA;
   logic [3:0] opB;
   logic       carryIn;
   logic       subtract;
   logic       decimal;
   logic [3:0] sum;
   logic       carryOut;

   modport core (output opA, output opB, output carryIn, output subtract,
                 output decimal, input sum, input carryOut);
   modport unit (input opA, input opB, input carryIn, input subtract,
                 input decimal, output sum, output carryOut);
endinterface

// file: hdl/cms_core.sv
/*
 * Memory-side core of the four-bit controller: instruction pointer,
 * one-entry return stack, general register and data memory, port
 * registers and the status flags, with a three-phase sequencer.
 * Assumes program memory answers romData for romAddr within the cycle,
 * and that pin levels arrive asynchronously.
 */
`timescale 1ns/100ps

module cms_core
   import cms_pkg::*;
(
   input  wire logic                 mclk,
   input  wire logic                 rst,
   input  wire logic [INSTR_W-1:0]   romData,
   input  wire logic [PORT_PINS-1:0] pinLevel,
   output logic      [IP_W-1:0]      romAddr,
   output logic      [PORT_PINS-1:0] portOut,
   output logic      [PORT_PINS-1:0] portOutEnN
);

   cms_state_type        state_q;
   cms_state_type        state_d;
   logic [IP_W-1:0]      ip_q;
   logic [IP_W-1:0]      ip_d;
   logic [IP_W-1:0]      stack_q;
   logic [INSTR_W-1:0]   instr_q;
   logic [DATA_W-1:0]    tmpA_q;
   logic [DATA_W-1:0]    tmpB_q;
   logic                 skip_q;
   logic                 skip_d;
   logic [DATA_W-1:0]    genReg_q [GEN_DEPTH];
   logic [PORT_PINS-1:0] portReg_q;
   logic [PORT_PINS-1:0] outEnN_q;
   logic [PORT_PINS-1:0] pinMeta_q;
   logic [PORT_PINS-1:0] pinSync_q;
   logic                 decimal_q;
   logic                 cmpHold_q;
   logic                 carry_q;
   logic                 zero_q;
   logic                 decimal_d;
   logic                 cmpHold_d;
   logic                 carry_d;
   logic                 zero_d;

   cms_alu_if aluIf ();

   cms_alu u_alu (
      .alu (aluIf)
   );

   // Reads any data address: general register, pins, status nibbles.
   // status bit map
   function automatic logic [3:0] readNibble(input logic [6:0] addr);
      logic [3:0] val;
      val = NIBBLE_RESET;
      if (addr[6:4] == ROW_POINTER) begin
         val = genReg_q[addr[3:0]];
      end else if (addr[6:2] == ADDR_PORT_BASE[6:2]) begin
         val = pinSync_q[{addr[1:0], 2'h0} +: DATA_W];
      end else if (addr == ADDR_STATUS_WORD) begin
         val[BIT_DECIMAL] = decimal_q;
      end else if (addr == ADDR_FLAG_NIBBLE) begin
         val[BIT_CMP]   = cmpHold_q;
         val[BIT_CARRY] = carry_q;
         val[BIT_ZERO]  = zero_q;
      end
      return val;
   endfunction

   // Instruction fields and opcode classes of the latched instruction.
   logic [3:0]      opcode;
   logic            immForm;
   logic [6:0]      mAddr;
   logic [3:0]      lowField;
   logic [IP_W-1:0] jumpAddr;
   logic            isArith;
   logic            isLogic;
   logic            isLoad;
   logic            isStore;
   logic            isBitTest;
   logic            isCompare;
   logic            isJump;
   logic            isCall;
   logic            isReturn;
   logic            isRotate;
   logic            useImm;

   assign opcode    = instr_q[OPC_MSB:OPC_LSB];
   assign immForm   = instr_q[FORM_BIT];
   assign mAddr     = instr_q[MADDR_MSB:MADDR_LSB];
   assign lowField  = instr_q[LOW_MSB:0];
   assign jumpAddr  = instr_q[JUMP_MSB:0];
   assign isArith   = (opcode <= OP_SUBC);
   assign isLogic   = (opcode == OP_OR) || (opcode == OP_AND)
                      || (opcode == OP_XOR);
   assign isLoad    = (opcode == OP_LOAD);
   assign isStore   = (opcode == OP_STORE);
   assign isBitTest = (opcode == OP_SKT) || (opcode == OP_SKF);
   assign isCompare = (opcode == OP_SKE) || (opcode == OP_SKIP_IF_UNEQUAL_OP)
                      || (opcode == OP_SKORD);
   assign isJump    = (opcode == OP_BRANCH) && !immForm;
   assign isCall    = (opcode == OP_BRANCH) && immForm;
   assign isReturn  = (opcode == OP_MISC) && !immForm;
   assign isRotate  = (opcode == OP_MISC) && immForm;
   // Tests always take immediate data; store, branch and rotate never do.
   assign useImm    = isBitTest || isCompare
                      || (immForm && !isStore && (opcode < OP_BRANCH));

   logic [6:0] regAddr;
   logic [3:0] mValue;
   logic [3:0] rValue;
   assign regAddr = {ROW_POINTER, lowField};
   logic [3:0] statusRd;
   logic [3:0] flagRd;
   // A process, not an assign: the reads must follow storage changes too.
   always_comb begin
      mValue   = readNibble(mAddr);
      rValue   = readNibble(regAddr);
      statusRd = readNibble(ADDR_STATUS_WORD);
      flagRd   = readNibble(ADDR_FLAG_NIBBLE);
   end

   assign aluIf.opA      = tmpA_q;
   assign aluIf.opB      = tmpB_q;
   assign aluIf.carryIn  = opcode[0] && carry_q;
   assign aluIf.subtract = opcode[1];
   assign aluIf.decimal  = decimal_q;

   logic execNow;
   logic arithNow;
   logic resultZero;
   assign execNow    = (state_q == ST_EXEC) && !skip_q;
   assign arithNow   = execNow && isArith;
   assign resultZero = (aluIf.sum == NIBBLE_RESET);

   // Skip conditions; comparisons use plain binary magnitude.
   logic below;
   logic skipTaken;
   assign below = (tmpA_q < tmpB_q);
   always_comb begin
      case (opcode)
         OP_SKT:   skipTaken = ((tmpA_q & tmpB_q) == tmpB_q);
         OP_SKF:   skipTaken = ((tmpA_q & tmpB_q) == NIBBLE_RESET);
         OP_SKE:   skipTaken = (tmpA_q == tmpB_q);
         OP_SKIP_IF_UNEQUAL_OP:  skipTaken = (tmpA_q != tmpB_q);
         OP_SKORD: skipTaken = immForm ? below : !below;
         default:  skipTaken = 1'b0;
      endcase
   end

   logic            memWe;
   logic [6:0]      wrAddr;
   logic [3:0]      wrData;
   logic            wrGen;
   logic            wrPort;
   logic            wrStatus;
   logic            wrFlags;
   assign memWe  = execNow && ((isArith && !cmpHold_q) || isLogic
                   || isLoad || isStore || isRotate);
   assign wrAddr = (useImm || isStore) ? mAddr : regAddr;
   always_comb begin
      case (opcode)
         OP_OR:    wrData = tmpA_q | tmpB_q;
         OP_AND:   wrData = tmpA_q & tmpB_q;
         OP_XOR:   wrData = tmpA_q ^ tmpB_q;
         OP_LOAD:  wrData = tmpB_q;
         OP_STORE: wrData = tmpA_q;
         OP_MISC:  wrData = {carry_q, tmpA_q[3:1]};
         default:  wrData = aluIf.sum;
      endcase
   end
   assign wrGen    = memWe && (wrAddr[6:4] == ROW_POINTER);
   assign wrPort   = memWe && (wrAddr[6:2] == ADDR_PORT_BASE[6:2]);
   assign wrStatus = memWe && (wrAddr == ADDR_STATUS_WORD);
   assign wrFlags  = memWe && (wrAddr == ADDR_FLAG_NIBBLE);

   // carry kept on compares
   // Flag updates from the operation win over a store to the same nibble.
   always_comb begin
      carry_d   = carry_q;
      zero_d    = zero_q;
      cmpHold_d = cmpHold_q;
      decimal_d = decimal_q;
      if (wrFlags) begin
         carry_d   = wrData[BIT_CARRY];
         zero_d    = wrData[BIT_ZERO];
         cmpHold_d = wrData[BIT_CMP];
      end
      if (wrStatus) begin
         decimal_d = wrData[BIT_DECIMAL];
      end
      if (arithNow) begin
         carry_d = aluIf.carryOut;
         zero_d  = resultZero ? (cmpHold_q ? zero_q : 1'b1) : 1'b0;
      end
      if (execNow && isRotate) begin
         carry_d = tmpA_q[0];
      end
      if (execNow && isBitTest) begin
         cmpHold_d = 1'b0;
      end
   end

   always_comb begin
      ip_d = ip_q;
      if (state_q == ST_EXEC) begin
         if (execNow && (isJump || isCall)) begin
            ip_d = jumpAddr;
         end else if (execNow && isReturn) begin
            ip_d = stack_q;
         end else begin
            ip_d = IP_W'(ip_q + IP_STEP);
         end
      end
   end
   assign skip_d = (state_q == ST_EXEC)
                   ? (execNow && (isBitTest || isCompare) && skipTaken)
                   : skip_q;

   // Sequencer: fetch, latch operands, execute.
   always_comb begin
      case (state_q)
         ST_FETCH: state_d = ST_LOAD;
         ST_LOAD:  state_d = ST_EXEC;
         ST_EXEC:  state_d = ST_FETCH;
         default:  state_d = ST_FETCH;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q <= ST_FETCH;
         ip_q    <= RESET_ADDR;
         skip_q  <= FLAG_RESET;
      end else begin
         state_q <= state_d;
         ip_q    <= ip_d;
         skip_q  <= skip_d;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         stack_q <= RESET_ADDR;
      end else if (execNow && isCall) begin
         stack_q <= IP_W'(ip_q + IP_STEP);
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         instr_q <= '0;
         tmpA_q  <= NIBBLE_RESET;
         tmpB_q  <= NIBBLE_RESET;
      end else if (state_q == ST_FETCH) begin
         instr_q <= romData;
      end else if (state_q == ST_LOAD) begin
         tmpA_q <= useImm ? mValue : rValue;
         tmpB_q <= useImm ? lowField : mValue;
      end
   end

   // General register storage; cleared so reads are defined after reset.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < GEN_DEPTH; i++) begin
            genReg_q[i] <= NIBBLE_RESET;
         end
      end else if (wrGen) begin
         genReg_q[wrAddr[3:0]] <= wrData;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         portReg_q <= PORT_RESET;
         outEnN_q  <= OE_N_RESET;
      end else if (wrPort) begin
         portReg_q[{wrAddr[1:0], 2'h0} +: DATA_W] <= wrData;
         outEnN_q[{wrAddr[1:0], 2'h0} +: DATA_W]  <= NIBBLE_RESET;
      end
   end

   // synchronised pin levels
   // Two stages because pins change with no regard to mclk.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pinMeta_q <= PORT_RESET;
         pinSync_q <= PORT_RESET;
      end else begin
         pinMeta_q <= pinLevel;
         pinSync_q <= pinMeta_q;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         decimal_q <= FLAG_RESET;
         cmpHold_q <= FLAG_RESET;
         carry_q   <= FLAG_RESET;
         zero_q    <= FLAG_RESET;
      end else begin
         decimal_q <= decimal_d;
         cmpHold_q <= cmpHold_d;
         carry_q   <= carry_d;
         zero_q    <= zero_d;
      end
   end

   assign romAddr    = ip_q;
   assign portOut    = portReg_q;
   assign portOutEnN = outEnN_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   stack_call_a: assert property (
      execNow && isCall |=> stack_q == IP_W'($past(ip_q) + IP_STEP)
   ) else $error("Call did not save the next address.");

   ret_reload_a: assert property (
      execNow && isReturn |=> ip_q == $past(stack_q)
   ) else $error("Return did not reload from the stack.");

   ip_hold_a: assert property (
      state_q != ST_EXEC |=> $stable(ip_q)
   ) else $error("Pointer moved outside the execute phase.");

   ip_step_a: assert property (
      state_q == ST_EXEC && !(execNow && (isJump || isCall || isReturn))
      |=> ip_q == IP_W'($past(ip_q) + IP_STEP)
   ) else $error("Pointer did not step by one.");

   port_drive_a: assert property (
      wrPort |=> portOutEnN[{$past(wrAddr[1:0]), 2'h0} +: 4] == 4'h0
                 && portOut[{$past(wrAddr[1:0]), 2'h0} +: 4]
                    == $past(wrData)
   ) else $error("Port write did not drive the value.");

   port_read_a: assert property (
      mAddr == ADDR_PORT_BASE |-> mValue == pinSync_q[3:0]
   ) else $error("Port read did not return pin levels.");

   flag_zero_bits_a: assert property (
      statusRd[3:1] == 3'h0 && flagRd[0] == 1'b0
   ) else $error("Fixed-zero status bits read nonzero.");

   zero_hold_a: assert property (
      arithNow && cmpHold_q && resultZero |=> $stable(zero_q)
   ) else $error("Zero flag changed under compare-hold.");

   hold_nostore_a: assert property (
      arithNow && cmpHold_q |-> !memWe
   ) else $error("Arithmetic result stored under compare-hold.");

   bit_test_clear_a: assert property (
      execNow && isBitTest |=> !cmpHold_q
   ) else $error("Bit test did not clear compare-hold.");

   compare_carry_a: assert property (
      execNow && isCompare |=> $stable(carry_q)
   ) else $error("Comparison changed the carry flag.");

   arith_carry_a: assert property (
      arithNow |=> carry_q == $past(aluIf.carryOut)
   ) else $error("Carry did not follow the arithmetic result.");

endmodule

// file: hdl/cms_pkg.sv
/*
 * Shared constants for the four-bit core: widths, data memory map,
 * status bit positions, instruction fields, opcodes and sequencer states.
 * Assumes nothing of its surroundings; every design file but the ALU interface imports it whole.
 */
package cms_pkg;

   // Widths and depths.
   localparam int IP_W       = 9;
   localparam int DATA_W     = 4;
   localparam int INSTR_W    = 16;
   localparam int DADDR_W    = 7;
   localparam int GEN_DEPTH  = 16;
   localparam int PORT_COUNT = 4;
   localparam int PORT_PINS  = 16;

   // Program memory span and reset start address.
   localparam logic [8:0] RESET_ADDR = 9'h000;
   localparam logic [8:0] PROG_LAST  = 9'h1FF;
   localparam logic [8:0] IP_STEP    = 9'h001;

   // Data memory map: row 0 is the general register, row 7 holds ports.
   localparam logic [2:0] ROW_POINTER      = 3'h0;
   localparam logic [6:0] ADDR_PORT_BASE   = 7'h70;
   localparam logic [6:0] ADDR_STATUS_WORD = 7'h7E;
   localparam logic [6:0] ADDR_FLAG_NIBBLE = 7'h7F;

   // Reset values.
   localparam logic [3:0]  NIBBLE_RESET = 4'h0;
   localparam logic [15:0] PORT_RESET   = 16'h0000;
   localparam logic [15:0] OE_N_RESET   = 16'hFFFF;
   localparam logic        FLAG_RESET   = 1'b0;

   // Status bit positions.
   localparam int BIT_DECIMAL = 0;
   localparam int BIT_ZERO    = 1;
   localparam int BIT_CARRY   = 2;
   localparam int BIT_CMP     = 3;

   // Instruction fields.
   localparam int OPC_MSB   = 15;
   localparam int OPC_LSB   = 12;
   localparam int FORM_BIT  = 11;
   localparam int MADDR_MSB = 10;
   localparam int MADDR_LSB = 4;
   localparam int LOW_MSB   = 3;
   localparam int JUMP_MSB  = 8;

   // Opcodes.
   localparam logic [3:0] OP_ADD     = 4'h0;
   localparam logic [3:0] OP_ADDC    = 4'h1;
   localparam logic [3:0] OP_SUB     = 4'h2;
   localparam logic [3:0] OP_SUBC    = 4'h3;
   localparam logic [3:0] OP_OR      = 4'h4;
   localparam logic [3:0] OP_AND     = 4'h5;
   localparam logic [3:0] OP_XOR     = 4'h6;
   localparam logic [3:0] OP_LOAD    = 4'h7;
   localparam logic [3:0] OP_STORE   = 4'h8;
   localparam logic [3:0] OP_SKT     = 4'h9;
   localparam logic [3:0] OP_SKF     = 4'hA;
   localparam logic [3:0] OP_SKE     = 4'hB;
   localparam logic [3:0] OP_SKIP_IF_UNEQUAL_OP    = 4'hC;
   localparam logic [3:0] OP_SKORD   = 4'hD;
   localparam logic [3:0] OP_BRANCH  = 4'hE;
   localparam logic [3:0] OP_MISC    = 4'hF;

   // Decimal correction.
   localparam logic [4:0] BCD_LIMIT = 5'h09;
   localparam logic [4:0] BCD_ADJ   = 5'h06;

   typedef enum logic [2:0] {
      ST_FETCH = 3'b001,
      ST_LOAD  = 3'b010,
      ST_EXEC  = 3'b100
   } cms_state_type;

endpackage

// file: testbench/cms_core_tb.sv
/*
 * Self-checking bench for the four-bit core: small programs run from a
 * program memory model and leave their results in the port registers.
 * Assumes the core takes one instruction per three cycles as handed over.
 */
`timescale 1ns/100ps
module cms_core_tb
   import cms_pkg::*;
;
   localparam int LIMIT = 2000;
   localparam logic [6:0] PT0 = 7'h70;
   localparam logic [6:0] PT1 = 7'h71;
   localparam logic [6:0] PT2 = 7'h72;
   localparam logic [6:0] PT3 = 7'h73;
   localparam logic [6:0] FLG = ADDR_FLAG_NIBBLE;
   localparam logic [6:0] DEC = ADDR_STATUS_WORD;

   logic        mclk;
   logic        rst;
   logic [15:0] romData;
   logic [15:0] pinLevel;
   logic [8:0]  romAddr;
   logic [15:0] portOut;
   logic [15:0] portOutEnN;
   logic [15:0] prog [512];
   int          numErrors;
   int          nCompared;
   int          cycleCount = 0;

   cms_core cms_core_i (
      .mclk       (mclk),
      .rst        (rst),
      .romData    (romData),
      .pinLevel   (pinLevel),
      .romAddr    (romAddr),
      .portOut    (portOut),
      .portOutEnN (portOutEnN)
   );

   // Program memory answers within the cycle, so it is a plain lookup.
   assign romData = prog[romAddr];

   // Free-running clock at 50 MHz.
   initial mclk = 1'b0;
   always #10 mclk = ~mclk;

   // Hang guard: the whole run needs a few hundred cycles at most.
   always @(posedge mclk) begin
      cycleCount <= cycleCount + 1;
      if (cycleCount == LIMIT) begin
         numErrors++;
         final_report();
      end
   end

   function automatic logic [15:0] ins(input logic [3:0] op,
                                       input logic fm,
                                       input logic [6:0] m,
                                       input logic [3:0] lo);
      return {op, fm, m, lo};
   endfunction

   function automatic logic [15:0] jmp(input logic fm, input logic [8:0] t);
      return {OP_BRANCH, fm, 2'h0, t};
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      nCompared++;
      if (seen !== exp) begin
         numErrors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("Compared %0d, mismatches %0d", nCompared, numErrors);
      if (numErrors == 0 && nCompared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Empty memory executes as harmless register adds; wipe between tests.
   task automatic clear();
      foreach (prog[i]) prog[i] = 16'h0000;
   endtask

   // Reset the core, run n instructions, then compare the visible state.
   task automatic run(input string name, input int n,
                      input logic [15:0] expOut, input logic [15:0] expEn,
                      input logic [8:0] expIp);
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      check({7'h00, romAddr}, 16'h0000);
      check(portOutEnN, 16'hFFFF);
      check(portOut, 16'h0000);
      @(posedge mclk);
      rst <= 1'b0;
      repeat (3 * n + 2) @(posedge mclk);
      #1;
      check(portOut, expOut);
      check(portOutEnN, expEn);
      check({7'h00, romAddr}, {7'h00, expIp});
      $display("Test %s done", name);
   endtask

   // Main sequence of programs.
   initial begin
      rst = 1'b1;
      pinLevel = 16'h0000;
      numErrors = 0;
      nCompared = 0;
      clear();
      // reset flags and fixed zero bits
      prog[0] = ins(OP_LOAD, 1'b1, PT0, 4'hA);
      prog[1] = ins(OP_LOAD, 1'b0, FLG, 4'h0);
      prog[2] = ins(OP_STORE, 1'b0, PT1, 4'h0);
      prog[3] = ins(OP_LOAD, 1'b1, DEC, 4'hF);
      prog[4] = ins(OP_LOAD, 1'b0, DEC, 4'h1);
      prog[5] = ins(OP_STORE, 1'b0, PT2, 4'h1);
      prog[6] = ins(OP_LOAD, 1'b1, FLG, 4'hF);
      prog[7] = ins(OP_LOAD, 1'b0, FLG, 4'h2);
      prog[8] = ins(OP_STORE, 1'b0, PT3, 4'h2);
      prog[9] = jmp(1'b0, 9'h009);
      run("status_map", 12, 16'hE10A, 16'h0000, 9'h009);
      clear();
      prog[0] = ins(OP_LOAD, 1'b1, 7'h00, 4'h9);
      prog[1] = ins(OP_ADD, 1'b1, 7'h00, 4'h8);
      prog[2] = ins(OP_LOAD, 1'b0, FLG, 4'h1);
      prog[3] = ins(OP_STORE, 1'b0, PT0, 4'h1);
      prog[4] = ins(OP_SUB, 1'b1, 7'h00, 4'h1);
      prog[5] = ins(OP_LOAD, 1'b0, FLG, 4'h1);
      prog[6] = ins(OP_STORE, 1'b0, PT1, 4'h1);
      prog[7] = ins(OP_LOAD, 1'b1, DEC, 4'h1);
      prog[8] = ins(OP_LOAD, 1'b1, 7'h02, 4'h5);
      prog[9] = ins(OP_ADD, 1'b1, 7'h02, 4'h8);
      prog[10] = ins(OP_STORE, 1'b0, PT2, 4'h2);
      prog[11] = ins(OP_SKE, 1'b1, 7'h02, 4'h3);
      prog[12] = ins(OP_LOAD, 1'b1, FLG, 4'h0);
      prog[13] = ins(OP_LOAD, 1'b0, FLG, 4'h3);
      prog[14] = ins(OP_STORE, 1'b0, PT3, 4'h3);
      prog[15] = jmp(1'b0, 9'h00F);
      run("arith_flags", 18, 16'h4324, 16'h0000, 9'h00F);
      clear();
      prog[0] = ins(OP_LOAD, 1'b1, 7'h00, 4'h5);
      prog[1] = ins(OP_LOAD, 1'b1, FLG, 4'hA);
      prog[2] = ins(OP_SUB, 1'b1, 7'h00, 4'h5);
      prog[3] = ins(OP_LOAD, 1'b0, FLG, 4'h1);
      prog[4] = ins(OP_STORE, 1'b0, PT0, 4'h1);
      prog[5] = ins(OP_SUB, 1'b1, 7'h00, 4'h4);
      prog[6] = ins(OP_SKT, 1'b1, 7'h00, 4'h4);
      prog[7] = ins(OP_LOAD, 1'b1, 7'h00, 4'h0);
      prog[8] = jmp(1'b1, 9'h1F0);
      prog[9] = ins(OP_STORE, 1'b0, PT1, 4'h0);
      prog[10] = ins(OP_LOAD, 1'b0, FLG, 4'h2);
      prog[11] = ins(OP_STORE, 1'b0, PT2, 4'h2);
      prog[12] = jmp(1'b0, 9'h00C);
      prog[9'h1F0] = ins(OP_LOAD, 1'b1, 7'h03, 4'h3);
      prog[9'h1F1] = ins(OP_MISC, 1'b1, 7'h00, 4'h3);
      prog[9'h1F2] = ins(OP_STORE, 1'b0, PT3, 4'h3);
      prog[9'h1F3] = ins(OP_MISC, 1'b0, 7'h00, 4'h0);
      run("hold_and_call", 22, 16'h145A, 16'h0000, 9'h00C);
      clear();
      // port reads return pins in both modes
      // Port 2 stays in input mode; ports 0 and 2 read pins, not registers.
      @(posedge mclk);
      pinLevel <= 16'h09C3;
      prog[0] = ins(OP_LOAD, 1'b1, PT0, 4'h5);
      prog[1] = ins(OP_LOAD, 1'b0, PT0, 4'h0);
      prog[2] = ins(OP_STORE, 1'b0, PT1, 4'h0);
      prog[3] = ins(OP_LOAD, 1'b0, PT2, 4'h1);
      prog[4] = ins(OP_STORE, 1'b0, PT3, 4'h1);
      prog[5] = jmp(1'b0, 9'h005);
      run("pin_read", 9, 16'h9035, 16'h0F00, 9'h005);
      final_report();
   end
endmodule
